// [rtl/dcc_pkg.sv]
// Shared constants, phase states and the state record of the comparator control block.
// Assumes a 32-bit APB slave where each register takes one aligned word.
package dcc_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL   = 8'h00; // Comparator control register.
  localparam logic [7:0] OFF_DIR    = 8'h04; // Port A direction register.
  localparam logic [7:0] OFF_FLAG   = 8'h08; // Peripheral flag register.
  localparam logic [7:0] OFF_PEN    = 8'h0C; // Peripheral enable register.
  localparam logic [7:0] OFF_INTC   = 8'h10; // Interrupt control register.
  localparam logic [7:0] OFF_STS    = 8'h14; // Sticky event status, read only.
  localparam logic [7:0] OFF_CLR    = 8'h18; // Event clear, write only.
  localparam logic [7:0] OFF_IEN    = 8'h1C; // Event interrupt enable.

  // Field positions.
  localparam int MODE_MSB   = 2;  // Mode field is bits 2:0.
  localparam int FIRST_BIT  = 6;  // First comparator output bit.
  localparam int SECOND_BIT = 7;  // Second comparator output bit.
  localparam int FLAG_BIT   = 6;  // Change flag in the flag register.
  localparam int CHGEN_BIT  = 6;  // Change enable in the enable register.
  localparam int PERIPHERAL_INT_ENABLE_BIT   = 6;  // Peripheral enable in interrupt control.
  localparam int GIE_BIT    = 7;  // Global enable in interrupt control.
  localparam int STS_CHG    = 0;  // Status bit for an output change.
  localparam int STS_MODE   = 1;  // Status bit for a mode change.

  // Mode codes.
  localparam logic [2:0] MODE_RESET  = 3'h0; // Pins 0 to 3 analogue, comparators off.
  localparam logic [2:0] MODE_INTREF = 3'h2; // Internal reference on both positives.
  localparam logic [2:0] MODE_OFF    = 3'h7; // Both comparators powered down.

  // Reset values.
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [4:0] DIR_RST  = 5'h1F;

  // Phase states of the instruction cycle.
  typedef enum logic [3:0] {
    DCC_PH1 = 4'h1,
    DCC_PH2 = 4'h2,
    DCC_PH3 = 4'h4,
    DCC_PH4 = 4'h8
  } dcc_phase_t;

  // Whole state of the block.
  typedef struct packed {
    dcc_phase_t  phase;     // Current phase.
    logic [2:0]  mode;      // Comparator mode field.
    logic [4:0]  dir;       // Port A direction, one means input.
    logic [1:0]  latched;   // Outputs remembered at the last control access.
    logic        flag;      // Comparator change flag.
    logic        chg_en;    // Comparator change enable.
    logic        per_en;    // Peripheral interrupt enable.
    logic        glb_en;    // Global interrupt enable.
    logic [1:0]  status;    // Sticky event status.
    logic [1:0]  irq_en;    // Event interrupt enables.
    logic [1:0]  outs;      // Registered comparator outputs.
    logic [31:0] rdata;     // Read data for the bus.
  } dcc_state_t;

endpackage : dcc_pkg

// [rtl/dcc_top.sv]
// Digital control around two voltage comparators, reached over APB.
// Assumes digitised analogue levels on its inputs, synchronous to i_clk.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps

module dcc_top (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // APB slave.
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic [31:0]      o_prdata,
  output logic             o_pslverr,
  // Digitised analogue levels.
  input  wire logic [7:0]  i_first_pos,
  input  wire logic [7:0]  i_first_neg,
  input  wire logic [7:0]  i_second_pos,
  input  wire logic [7:0]  i_second_neg,
  input  wire logic [7:0]  i_ref_level,
  // Power state of the core.
  input  wire logic        i_sleep,
  // Comparator and pin control.
  output logic             o_cmp_power,
  output logic [1:0]       o_cmp_out,
  output logic [4:0]       o_pin_analog,
  output logic [4:0]       o_pin_oe,
  // Interrupts.
  output logic             o_int_request,
  output logic             o_wake,
  output logic             o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // True when the mode leaves both comparators powered.
  function automatic logic powered(input logic [2:0] m);
    powered = (m != dcc_pkg::MODE_RESET) && (m != dcc_pkg::MODE_OFF);
  endfunction : powered

  // Pins left analogue by a mode; bit 4 is never analogue.
  function automatic logic [4:0] analog_mask(input logic [2:0] m);
    case (m)
      3'h7:    analog_mask = 5'h00;
      3'h3,
      3'h5,
      3'h6:    analog_mask = 5'h07;
      default: analog_mask = 5'h0F;
    endcase
  endfunction : analog_mask

  // True for an offset that decodes to a register.
  function automatic logic hit(input logic [7:0] a);
    hit = (a[1:0] == 2'h0) && (a <= dcc_pkg::OFF_IEN);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // State and decode.

  dcc_pkg::dcc_state_t st_reg;   // Registered state.
  dcc_pkg::dcc_state_t st_next;  // Its next value.
  logic [7:0]          addr;     // Low address byte.
  logic                access;   // APB access phase.
  logic                rd_take;  // Read taken this cycle.
  logic                wr_take;  // Write taken this cycle.
  logic                ctrl_acc; // Control register read or written.
  logic [7:0]          pos1;     // Positive input of the first comparator.
  logic [7:0]          pos2;     // Positive input of the second comparator.
  logic [1:0]          live;     // Live comparator outputs.
  logic                mismatch; // Live outputs differ from latched ones.
  logic                set_chg;  // Change event that sets the flag.

  assign addr   = i_paddr[7:0];
  assign access = i_psel && i_penable;

  // A read completes in phase two and a write in phase four, so the bus
  // waits for the phase; this costs up to four cycles per access.
  assign rd_take  = access && !i_pwrite && (st_reg.phase == dcc_pkg::DCC_PH2);
  assign wr_take  = access && i_pwrite && (st_reg.phase == dcc_pkg::DCC_PH4);
  assign ctrl_acc = (rd_take || wr_take) && (addr == dcc_pkg::OFF_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // Comparators.

  // The internal reference replaces both positive pins in mode 010.
  assign pos1 = (st_reg.mode == dcc_pkg::MODE_INTREF) ? i_ref_level : i_first_pos;
  assign pos2 = (st_reg.mode == dcc_pkg::MODE_INTREF) ? i_ref_level : i_second_pos;

  // Equal levels resolve low; a powered-down comparator reads low.
  // Sleep has no effect here, so the comparators keep running.
  always_comb begin
    live[0] = powered(st_reg.mode) && (pos1 > i_first_neg);
    live[1] = powered(st_reg.mode) && (pos2 > i_second_neg);
  end

  // A mismatch is found by comparing latched and live every cycle.
  assign mismatch = (live != st_reg.latched);

  // A change in the cycle the control register is accessed is lost, since
  // the access refreshes the latch in that very cycle.
  assign set_chg = mismatch && !ctrl_acc;

  ////////////////////////////////////////////////////////////////////////////
  // Next state.

  // All register updates and the phase divider live in this process.
  always_comb begin
    st_next = st_reg;
    // Phase divider, one step per clock.
    case (st_reg.phase)
      dcc_pkg::DCC_PH1: begin
        st_next.phase = dcc_pkg::DCC_PH2;
      end
      dcc_pkg::DCC_PH2: begin
        st_next.phase = dcc_pkg::DCC_PH3;
      end
      dcc_pkg::DCC_PH3: begin
        st_next.phase = dcc_pkg::DCC_PH4;
      end
      default: begin
        st_next.phase = dcc_pkg::DCC_PH1;
      end
    endcase
    // Any access to the control register refreshes the latch.
    if (ctrl_acc) begin
      st_next.latched = live;
    end
    st_next.outs = live;
    // Register writes.
    if (wr_take) begin
      case (addr)
        dcc_pkg::OFF_CTRL: begin
          st_next.mode = i_pwdata[dcc_pkg::MODE_MSB:0];
          if (i_pwdata[dcc_pkg::MODE_MSB:0] != st_reg.mode) begin
            st_next.status[dcc_pkg::STS_MODE] = 1'b1;
          end
        end
        dcc_pkg::OFF_DIR: begin
          st_next.dir = i_pwdata[4:0];
        end
        dcc_pkg::OFF_FLAG: begin
          // Zero clears, one simulates an event.
          st_next.flag = i_pwdata[dcc_pkg::FLAG_BIT];
        end
        dcc_pkg::OFF_PEN: begin
          st_next.chg_en = i_pwdata[dcc_pkg::CHGEN_BIT];
        end
        dcc_pkg::OFF_INTC: begin
          st_next.per_en = i_pwdata[dcc_pkg::PERIPHERAL_INT_ENABLE_BIT];
          st_next.glb_en = i_pwdata[dcc_pkg::GIE_BIT];
        end
        dcc_pkg::OFF_CLR: begin
          st_next.status = st_reg.status & ~i_pwdata[1:0];
        end
        dcc_pkg::OFF_IEN: begin
          st_next.irq_en = i_pwdata[1:0];
        end
        default: begin
          st_next.irq_en = st_reg.irq_en;
        end
      endcase
    end
    // Hardware set wins over a software clear in the same cycle.
    if (set_chg) begin
      st_next.flag                   = 1'b1;
      st_next.status[dcc_pkg::STS_CHG] = 1'b1;
    end
    // Read data follows the address; it is rebuilt every cycle from the current state and live outputs.
    st_next.rdata = 32'h0000_0000;
    case (addr)
      dcc_pkg::OFF_CTRL: begin
        st_next.rdata[dcc_pkg::MODE_MSB:0] = st_reg.mode;
        st_next.rdata[dcc_pkg::FIRST_BIT]  = live[0];
        st_next.rdata[dcc_pkg::SECOND_BIT] = live[1];
      end
      dcc_pkg::OFF_DIR: begin
        st_next.rdata[4:0] = st_reg.dir;
      end
      dcc_pkg::OFF_FLAG: begin
        st_next.rdata[dcc_pkg::FLAG_BIT] = st_reg.flag;
      end
      dcc_pkg::OFF_PEN: begin
        st_next.rdata[dcc_pkg::CHGEN_BIT] = st_reg.chg_en;
      end
      dcc_pkg::OFF_INTC: begin
        st_next.rdata[dcc_pkg::PERIPHERAL_INT_ENABLE_BIT] = st_reg.per_en;
        st_next.rdata[dcc_pkg::GIE_BIT]  = st_reg.glb_en;
      end
      dcc_pkg::OFF_STS: begin
        st_next.rdata[1:0] = st_reg.status;
      end
      dcc_pkg::OFF_IEN: begin
        st_next.rdata[1:0] = st_reg.irq_en;
      end
      default: begin
        st_next.rdata = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.

  // Reset forces mode 000; sleep is not a reset, so only a control write changes it otherwise.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg         <= '0;
      st_reg.phase   <= dcc_pkg::DCC_PH1;
      st_reg.mode    <= dcc_pkg::CTRL_RST;
      st_reg.dir     <= dcc_pkg::DIR_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign o_pready  = i_pwrite ? (st_reg.phase == dcc_pkg::DCC_PH4)
                              : (st_reg.phase == dcc_pkg::DCC_PH2);
  assign o_pslverr = access && o_pready && !hit(addr);
  assign o_prdata  = st_reg.rdata;

  // Comparators are held off while reset is asserted.
  assign o_cmp_power  = powered(st_reg.mode) && !i_rst;
  assign o_cmp_out    = st_reg.outs;
  assign o_pin_analog = analog_mask(st_reg.mode);
  // A digital pin drives only when its direction bit says output.
  assign o_pin_oe     = ~st_reg.dir & ~analog_mask(st_reg.mode);

  // The flag sets regardless; the request needs all three enables.
  assign o_int_request = st_reg.flag && st_reg.chg_en && st_reg.per_en && st_reg.glb_en;
  // Wake ignores the global enable.
  assign o_wake = i_sleep && st_reg.flag && st_reg.chg_en && st_reg.per_en;
  assign o_irq  = |(st_reg.status & st_reg.irq_en);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence ctrl_access_s;
    ctrl_acc;
  endsequence

  sequence read_done_s;
    access && !i_pwrite && o_pready;
  endsequence

  flag_set_a: assert property (set_chg |=> st_reg.flag)
    else $error("change flag not set on mismatch");
  irq_gate_a: assert property (!st_reg.glb_en |-> !o_int_request)
    else $error("request without global enable");
  latch_refresh_a: assert property (ctrl_access_s |=> st_reg.latched == $past(live))
    else $error("control access did not end mismatch");
  read_phase_a: assert property (read_done_s |-> $past(st_reg.phase) == dcc_pkg::DCC_PH1)
    else $error("read not in phase two");
  mode_write_a: assert property (wr_take && addr == dcc_pkg::OFF_CTRL
                                 |=> st_reg.mode == $past(i_pwdata[2:0]))
    else $error("mode field not written");
  intref_a: assert property (st_reg.mode == dcc_pkg::MODE_INTREF
                             |-> live[0] == (i_ref_level > i_first_neg))
    else $error("internal reference not used");
  power_off_a: assert property (st_reg.mode == dcc_pkg::MODE_OFF
                                |-> !o_cmp_power && live == 2'h0)
    else $error("comparators not off in mode 111");
  reset_mode_a: assert property (@(posedge i_clk) disable iff (1'b0)
                                 i_rst |=> st_reg.mode == dcc_pkg::MODE_RESET)
    else $error("reset did not force mode 000");
  wake_a: assert property (i_sleep && st_reg.flag && st_reg.chg_en && st_reg.per_en
                           |-> o_wake)
    else $error("no wake from comparator event");

  // Two change events in a row, with no control access to end the mismatch.
  sequence persist_s;
    set_chg [*2];
  endsequence

  // The flag must still be up after a mismatch that lasted two cycles, even
  // if software tried to clear it in between.
  rearm_a: assert property (persist_s |=> st_reg.flag && $past(st_reg.flag))
    else $error("flag not re-set while mismatch persists");

  // A software clear of the change flag, the bit written as zero.
  sequence flag_clear_s;
    wr_take && (addr == dcc_pkg::OFF_FLAG) && !i_pwdata[dcc_pkg::FLAG_BIT];
  endsequence

  // A read of the control register in its bus phase.
  sequence ctrl_read_s;
    rd_take && (addr == dcc_pkg::OFF_CTRL);
  endsequence

  // A write to the control register in its bus phase.
  sequence ctrl_write_s;
    wr_take && (addr == dcc_pkg::OFF_CTRL);
  endsequence

  // A clear only sticks when no change event falls on the same edge.
  flag_clear_a: assert property (flag_clear_s |=> st_reg.flag == $past(set_chg))
    else $error("flag clear did not follow the set-wins order");

  // Without a competing event the written bit lands, zero or one.
  flag_write_a: assert property (wr_take && (addr == dcc_pkg::OFF_FLAG) && !set_chg
                                 |=> st_reg.flag == $past(i_pwdata[dcc_pkg::FLAG_BIT]))
    else $error("flag write did not land");

  // A control read carries the mode and the outputs of the cycle before.
  ctrl_read_a: assert property (ctrl_read_s
                                |-> (o_prdata[dcc_pkg::FIRST_BIT] == $past(live[0]))
                                    && (o_prdata[dcc_pkg::SECOND_BIT] == $past(live[1]))
                                    && (o_prdata[dcc_pkg::MODE_MSB:0] == $past(st_reg.mode)))
    else $error("control read data wrong");

  // A change on the edge of a control access is dropped, not flagged.
  lost_change_a: assert property (ctrl_acc && !st_reg.flag |=> !st_reg.flag)
    else $error("flag set during a control access");

  // A written mode that differs from the old one marks the mode status bit.
  mode_status_a: assert property (ctrl_write_s && (i_pwdata[2:0] != st_reg.mode)
                                  |=> st_reg.status[dcc_pkg::STS_MODE])
    else $error("mode change not recorded");

  // The change status bit stays set until software clears it.
  status_hold_a: assert property (st_reg.status[dcc_pkg::STS_CHG]
                                  && !(wr_take && (addr == dcc_pkg::OFF_CLR))
                                  |=> st_reg.status[dcc_pkg::STS_CHG])
    else $error("change status lost without a clear");

  // The second comparator also sees the reference in mode 010.
  intref_two_a: assert property (st_reg.mode == dcc_pkg::MODE_INTREF
                                 |-> live[1] == (i_ref_level > i_second_neg))
    else $error("internal reference not used by the second comparator");

  // A driven pin is never an input by direction nor left analogue.
  pin_drive_a: assert property (((o_pin_oe & st_reg.dir) == 5'h00)
                                && ((o_pin_oe & o_pin_analog) == 5'h00))
    else $error("pin driven against its direction or mode");

  // The phase divider wraps from phase four back to phase one.
  phase_order_a: assert property (st_reg.phase == dcc_pkg::DCC_PH4
                                  |=> st_reg.phase == dcc_pkg::DCC_PH1)
    else $error("phase divider out of order");

  // A write is only taken in phase four, so phase one follows it.
  write_phase_a: assert property (wr_take |=> st_reg.phase == dcc_pkg::DCC_PH1)
    else $error("write not in phase four");

  // The comparators stay off for the whole reset interval.
  reset_power_a: assert property (@(posedge i_clk) disable iff (1'b0)
                                  i_rst |-> !o_cmp_power)
    else $error("comparators powered during reset");

  // Sleep alone never alters the control register contents.
  sleep_keep_a: assert property (i_sleep && !wr_take |=> $stable(st_reg.mode))
    else $error("control register changed in sleep");

  // Registered outputs follow the live decisions one cycle later; the cycle
  // after reset is skipped, as the outputs were cleared rather than copied.
  cmp_out_a: assert property (!$past(i_rst) |-> o_cmp_out == $past(live))
    else $error("registered outputs do not follow the comparators");

endmodule : dcc_top

// [verification/dcc_top_tb.sv]
// Self-checking testbench for the comparator control block.
// Assumes the block answers APB in its own phase and needs no partner model.
`timescale 1ns/10ps

module dcc_top_tb;
  // Clock, reset and bus signals driven by the bench.
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [31:0] i_paddr = 32'h0, i_pwdata = 32'h0;
  logic [7:0]  i_first_pos = 8'h0, i_first_neg = 8'h0;
  logic [7:0]  i_second_pos = 8'h0, i_second_neg = 8'h0, i_ref_level = 8'h0;
  logic        i_sleep = 1'b0;
  // Observed outputs.
  logic        o_pready, o_pslverr, o_cmp_power, o_int_request, o_wake, o_irq;
  logic [31:0] o_prdata;
  logic [1:0]  o_cmp_out;
  logic [4:0]  o_pin_analog, o_pin_oe;
  // Bookkeeping.
  int          n_mismatch = 0;
  int          samples_checked = 0;
  logic [31:0] q;
  logic        last_err;

  dcc_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_first_pos(i_first_pos),
    .i_first_neg(i_first_neg), .i_second_pos(i_second_pos), .i_second_neg(i_second_neg),
    .i_ref_level(i_ref_level), .i_sleep(i_sleep), .o_cmp_power(o_cmp_power),
    .o_cmp_out(o_cmp_out), .o_pin_analog(o_pin_analog), .o_pin_oe(o_pin_oe),
    .o_int_request(o_int_request), .o_wake(o_wake), .o_irq(o_irq));

  // 125 MHz clock.
  always #4 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////////
  // Report a difference between seen and expected values.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer. pready is sampled at the rising edge itself, where the
  // design's registers still show their old values; that edge takes the transfer.
  // A hang is left to the watchdog; a wait of more than four cycles counts as a mismatch.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel    <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite  <= w;
    i_paddr   <= {24'h000000, a};
    i_pwdata  <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1);
    q        = o_prdata;
    last_err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
    check((n <= 4), 1'b1);
  endtask : apb

  // Let register updates land before port outputs are compared.
  task automatic settle();
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
  endtask : settle

  // Verdict; the only place where the run ends.
  task automatic results();
    $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the whole sequence needs under five hundred cycles.
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    results();
  end

  // Main sequence.
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    apb(1'b0, dcc_pkg::OFF_CTRL, 32'h0);
    check(q[7:0], 8'h00);
    apb(1'b0, dcc_pkg::OFF_DIR, 32'h0);
    check(q[4:0], dcc_pkg::DIR_RST);
    check(o_cmp_power, 1'b0);
    $display("reset values done");

    // Every mode with equal inputs, so no output changes; the change
    // interrupt stays masked while modes are switched.
    apb(1'b1, dcc_pkg::OFF_PEN, 32'h0);
    for (int m = 0; m < 8; m++) begin
      apb(1'b1, dcc_pkg::OFF_CTRL, m);
      apb(1'b0, dcc_pkg::OFF_CTRL, 32'h0);
      settle();
      check(q[2:0], m[2:0]);
      check(o_cmp_power, (m != 0 && m != 7));
      check(o_pin_analog, (m == 7) ? 5'h00 : (m == 3 || m == 5 || m == 6) ? 5'h07 : 5'h0F);
    end
    apb(1'b0, dcc_pkg::OFF_STS, 32'h0);
    check(q[1:0], 2'h2);
    $display("mode loop done");

    // Direction register decides which non-analogue pins are driven.
    apb(1'b1, dcc_pkg::OFF_CTRL, 32'h3);
    apb(1'b1, dcc_pkg::OFF_DIR, 32'h7);
    settle();
    check(o_pin_oe, 5'h18);
    apb(1'b1, dcc_pkg::OFF_DIR, 32'h10);
    settle();
    check(o_pin_oe, 5'h08);
    $display("direction done");

    // Comparator decisions, equal inputs giving a low output.
    apb(1'b1, dcc_pkg::OFF_CTRL, 32'h1);
    i_first_pos  <= 8'h80;
    i_first_neg  <= 8'h40;
    i_second_pos <= 8'h20;
    i_second_neg <= 8'h20;
    settle();
    apb(1'b0, dcc_pkg::OFF_CTRL, 32'h0);
    check(q[7:6], 2'h1);
    check(o_cmp_out, 2'h1);
    apb(1'b1, dcc_pkg::OFF_CTRL, 32'h2);
    i_first_pos <= 8'h00;
    i_ref_level <= 8'h30;
    settle();
    apb(1'b0, dcc_pkg::OFF_CTRL, 32'h0);
    check(q[7:6], 2'h2);
    $display("comparator done");

    // Change flag: set by a mismatch, held while it lasts.
    apb(1'b1, dcc_pkg::OFF_FLAG, 32'h0);
    apb(1'b0, dcc_pkg::OFF_FLAG, 32'h0);
    check(q[6], 1'b0);
    i_ref_level <= 8'h10;
    settle();
    apb(1'b0, dcc_pkg::OFF_FLAG, 32'h0);
    check(q[6], 1'b1);
    apb(1'b1, dcc_pkg::OFF_FLAG, 32'h0);
    apb(1'b0, dcc_pkg::OFF_FLAG, 32'h0);
    check(q[6], 1'b1);
    apb(1'b0, dcc_pkg::OFF_CTRL, 32'h0);
    apb(1'b1, dcc_pkg::OFF_FLAG, 32'h0);
    apb(1'b0, dcc_pkg::OFF_FLAG, 32'h0);
    check(q[6], 1'b0);
    apb(1'b1, dcc_pkg::OFF_FLAG, 32'h40);
    apb(1'b0, dcc_pkg::OFF_FLAG, 32'h0);
    check(q[6], 1'b1);
    $display("change flag done");

    // Every enable combination, in sleep, with the flag set.
    i_sleep <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, dcc_pkg::OFF_PEN, {25'h0, k[0], 6'h0});
      apb(1'b1, dcc_pkg::OFF_INTC, {24'h0, k[2], k[1], 6'h0});
      settle();
      check(o_int_request, (k == 7));
      check(o_wake, (k[0] & k[1]));
    end
    @(posedge i_clk);
    i_sleep <= 1'b0;
    apb(1'b0, dcc_pkg::OFF_CTRL, 32'h0);
    check(q[2:0], 3'h2);
    $display("interrupt gating done");

    // Sticky status, its enable and clear, and an unmapped address.
    apb(1'b1, dcc_pkg::OFF_IEN, 32'h1);
    settle();
    check(o_irq, 1'b1);
    apb(1'b1, dcc_pkg::OFF_CLR, 32'h3);
    settle();
    check(o_irq, 1'b0);
    apb(1'b0, 8'h20, 32'h0);
    check({last_err, q}, {1'b1, 32'h0});
    $display("status done");

    // Reset in mid-run.
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    apb(1'b0, dcc_pkg::OFF_CTRL, 32'h0);
    check(q[2:0], dcc_pkg::MODE_RESET);
    $display("second reset done");
    results();
  end
endmodule : dcc_top_tb
